// file: hw/sbs_status_core.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module sbs_status_core
	import sbs_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [STAT_W-1:0] std_event_in,
	input  wire logic [STAT_W-1:0] oper_event_in,
	input  wire logic [STAT_W-1:0] meas_event_in,
	input  wire logic [STAT_W-1:0] ques_event_in,
	input  wire logic [STAT_W-1:0] oper_cond_in,
	input  wire logic [STAT_W-1:0] meas_cond_in,
	input  wire logic [STAT_W-1:0] ques_cond_in,
	input  wire logic              output_queue_nonempty,
	input  wire logic              error_queue_push,
	input  wire logic              error_queue_pop,
	input  wire logic              output_queue_clear,
	input  wire logic              clear_status,
	input  wire logic              status_preset,
	input  wire logic              queue_clear,
	input  wire logic              system_clear,
	input  wire logic              system_preset,
	input  wire logic              instrument_reset,
	input  wire logic [2:0]        wr_sel,
	input  wire logic [STAT_W-1:0] wr_data,
	input  wire logic              rd_req,
	input  wire logic [3:0]        rd_sel,
	input  wire logic              serial_poll,
	output logic      [STAT_W-1:0] rd_data,
	output logic                   rd_valid,
	output logic      [BYTE_W-1:0] poll_byte,
	output logic                   poll_valid,
	output logic      [BYTE_W-1:0] status_summary_byte,
	output logic                   service_request,
	output logic                   error_queue_nonempty_flag,
	output logic                   questionable_summary_flag,
	output logic                   operation_summary_flag
);

	localparam int EQ_CNT_W = 5;
	localparam logic [EQ_CNT_W-1:0] EQ_DEPTH = 5'h0A;
	localparam logic [EQ_CNT_W-1:0] EQ_ONE = 5'h01;

	// State of the core outside the event register sets
	typedef struct packed {
		logic [BYTE_W-1:0]   srq_en;
		logic [EQ_CNT_W-1:0] eq_cnt;
		sbs_rq_e             rq;
		logic [STAT_W-1:0]   rdat;
		logic                rval;
		logic [BYTE_W-1:0]   pbyte;
		logic                pval;
	} sbs_core_s;

	sbs_core_s st_r;
	sbs_core_s st_nxt;

	logic [NSETS-1:0]  summ;
	logic [STAT_W-1:0] ev_q [NSETS];
	logic [STAT_W-1:0] en_q [NSETS];
	logic [STAT_W-1:0] ev_in [NSETS];
	logic [NSETS-1:0]  ev_clr;
	logic [NSETS-1:0]  en_wr;
	logic [NSETS-1:0]  en_clr;
	logic [BYTE_W-1:0] sb_raw;
	logic              mss;
	logic              std_rd;

	// Decode an enable write select onto the event set it targets
	function automatic logic [NSETS-1:0] wsel_dec(input logic [2:0] s);
		logic [NSETS-1:0] d;
		d = '0;
		if (s == SBS_WR_STD_EN)
			d[SET_STD] = 1'b1;
		else if (s == SBS_WR_OPER_EN)
			d[SET_OPER] = 1'b1;
		else if (s == SBS_WR_MEAS_EN)
			d[SET_MEAS] = 1'b1;
		else if (s == SBS_WR_QUES_EN)
			d[SET_QUES] = 1'b1;
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Event register sets
	assign ev_in[SET_STD] = std_event_in;
	assign ev_in[SET_OPER] = oper_event_in;
	assign ev_in[SET_MEAS] = meas_event_in;
	assign ev_in[SET_QUES] = ques_event_in;
	assign std_rd = rd_req && (rd_sel == SBS_RD_STD_EV);
	assign en_wr = wsel_dec(wr_sel);

	// Control strobes per set; system preset and reset touch nothing
	always_comb
	begin
		ev_clr = {NSETS{clear_status}};
		ev_clr[SET_STD] = clear_status | std_rd;
		en_clr = {NSETS{status_preset}};
		en_clr[SET_STD] = 1'b0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NSETS; gi++)
		begin : g_set
			sbs_event_set u_set (
				.mclk     (mclk),
				.rst      (rst),
				.bit_mask ((gi == SET_STD) ? STD_MASK : STAT_MASK),
				.ev_in    (ev_in[gi]),
				.ev_clr   (ev_clr[gi]),
				.en_wr    (en_wr[gi]),
				.en_clr   (en_clr[gi]),
				.en_data  (wr_data),
				.ev_q     (ev_q[gi]),
				.en_q     (en_q[gi]),
				.summary  (summ[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Status byte, live from its sources
	always_comb
	begin
		sb_raw = BYTE_RST;
		sb_raw[SB_MEAS_BIT] = summ[SET_MEAS];
		sb_raw[SB_ERRQ_BIT] = (st_r.eq_cnt != '0);
		sb_raw[SB_QUES_BIT] = summ[SET_QUES];
		sb_raw[SB_OUTQ_BIT] = output_queue_nonempty;
		sb_raw[SB_STD_BIT] = summ[SET_STD];
		sb_raw[SB_OPER_BIT] = summ[SET_OPER];
	end

	// Master summary: AND with enables then OR
	assign mss = |(sb_raw & st_r.srq_en & ~(BYTE_W'(1) << SB_RQS_BIT));

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rval = 1'b0;
		st_nxt.pval = 1'b0;

		// Request enable write; zero clears it
		if (wr_sel == SBS_WR_SRQ_EN)
			st_nxt.srq_en = wr_data[BYTE_W-1:0];

		// Error queue occupancy; clear commands empty it
		if (clear_status || queue_clear || system_clear)
			st_nxt.eq_cnt = '0;
		else if (error_queue_push && !error_queue_pop
				&& st_r.eq_cnt != EQ_DEPTH)
			st_nxt.eq_cnt = st_r.eq_cnt + EQ_ONE;
		else if (error_queue_pop && !error_queue_push
				&& st_r.eq_cnt != '0)
			st_nxt.eq_cnt = st_r.eq_cnt - EQ_ONE;

		// Service request: poll clears it, new enabled rise rearms
		case (st_r.rq)
			SBS_IDLE:
				if (mss)
					st_nxt.rq = SBS_REQ;
			SBS_REQ:
				if (serial_poll)
					st_nxt.rq = mss ? SBS_ARMED : SBS_IDLE;
			SBS_ARMED:
				if (!mss)
					st_nxt.rq = SBS_IDLE;
				else if (|(sb_raw & st_r.srq_en & ~st_r.pbyte))
					st_nxt.rq = SBS_REQ;
			default:
				st_nxt.rq = SBS_IDLE;
		endcase

		// Serial poll answer: bit 6 is the request flag
		if (serial_poll)
		begin
			st_nxt.pbyte = sb_raw;
			st_nxt.pbyte[SB_RQS_BIT] = (st_r.rq == SBS_REQ);
			st_nxt.pval = 1'b1;
		end

		// Query answer; bit 6 of the status byte is master summary
		if (rd_req)
		begin
			st_nxt.rval = 1'b1;
			case (rd_sel)
				SBS_RD_STB:
					st_nxt.rdat = {8'h00, sb_raw | (8'(mss) << SB_RQS_BIT)};
				SBS_RD_SRQ_EN:
					st_nxt.rdat = {8'h00, st_r.srq_en};
				SBS_RD_STD_EV:
					st_nxt.rdat = ev_q[SET_STD];
				SBS_RD_STD_EN:
					st_nxt.rdat = en_q[SET_STD];
				SBS_RD_OPER_EV:
					st_nxt.rdat = ev_q[SET_OPER];
				SBS_RD_OPER_EN:
					st_nxt.rdat = en_q[SET_OPER];
				SBS_RD_OPER_CD:
					st_nxt.rdat = oper_cond_in & STAT_MASK;
				SBS_RD_MEAS_EV:
					st_nxt.rdat = ev_q[SET_MEAS];
				SBS_RD_MEAS_EN:
					st_nxt.rdat = en_q[SET_MEAS];
				SBS_RD_MEAS_CD:
					st_nxt.rdat = meas_cond_in & STAT_MASK;
				SBS_RD_QUES_EV:
					st_nxt.rdat = ev_q[SET_QUES];
				SBS_RD_QUES_EN:
					st_nxt.rdat = en_q[SET_QUES];
				SBS_RD_QUES_CD:
					st_nxt.rdat = ques_cond_in & STAT_MASK;
				default:
					st_nxt.rdat = STAT_RST;
			endcase
		end
	end

	// State registers, cleared at power-on
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_r <= '{srq_en: BYTE_RST, eq_cnt: '0, rq: SBS_IDLE,
				rdat: STAT_RST, rval: 1'b0, pbyte: BYTE_RST, pval: 1'b0};
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign rd_data = st_r.rdat;
	assign rd_valid = st_r.rval;
	assign poll_byte = st_r.pbyte;
	assign poll_valid = st_r.pval;
	assign status_summary_byte = sb_raw | (8'(mss) << SB_RQS_BIT);
	assign service_request = (st_r.rq == SBS_REQ);
	assign error_queue_nonempty_flag = sb_raw[SB_ERRQ_BIT];
	assign questionable_summary_flag = sb_raw[SB_QUES_BIT];
	assign operation_summary_flag = sb_raw[SB_OPER_BIT];

endmodule // sbs_status_core

// file: common/sbs_pkg.sv
package sbs_pkg;

	// Register widths
	localparam int STAT_W = 16;
	localparam int BYTE_W = 8;

	// Status byte bit positions
	localparam int SB_MEAS_BIT = 0;
	localparam int SB_UNUSED_BIT = 1;
	localparam int SB_ERRQ_BIT = 2;
	localparam int SB_QUES_BIT = 3;
	localparam int SB_OUTQ_BIT = 4;
	localparam int SB_STD_BIT = 5;
	localparam int SB_RQS_BIT = 6;
	localparam int SB_OPER_BIT = 7;

	// Reset values
	localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

	// Mask of settable bits in a 16-bit status register (top bit never set)
	localparam logic [STAT_W-1:0] STAT_MASK = 16'h7FFF;

	// Standard event register is 8 bits, held in low byte
	localparam logic [STAT_W-1:0] STD_MASK = 16'h00FF;

	// Event set indices for the generate loop
	localparam int SET_STD = 0;
	localparam int SET_OPER = 1;
	localparam int SET_MEAS = 2;
	localparam int SET_QUES = 3;
	localparam int NSETS = 4;

	// Enable-register write selects
	typedef enum logic [2:0] {
		SBS_WR_NONE,
		SBS_WR_STD_EN,
		SBS_WR_OPER_EN,
		SBS_WR_MEAS_EN,
		SBS_WR_QUES_EN,
		SBS_WR_SRQ_EN
	} sbs_wsel_e;

	// Register query selects
	typedef enum logic [3:0] {
		SBS_RD_STB,
		SBS_RD_SRQ_EN,
		SBS_RD_STD_EV,
		SBS_RD_STD_EN,
		SBS_RD_OPER_EV,
		SBS_RD_OPER_EN,
		SBS_RD_OPER_CD,
		SBS_RD_MEAS_EV,
		SBS_RD_MEAS_EN,
		SBS_RD_MEAS_CD,
		SBS_RD_QUES_EV,
		SBS_RD_QUES_EN,
		SBS_RD_QUES_CD
	} sbs_rsel_e;

	// Service request state machine
	typedef enum logic [1:0] {
		SBS_IDLE,
		SBS_REQ,
		SBS_ARMED
	} sbs_rq_e;

endpackage

// file: hw/sbs_event_set.sv
`timescale 1ns/1ps
// One event register set: sticky event bits plus enable mask and summary
module sbs_event_set
	import sbs_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [STAT_W-1:0] bit_mask,
	input  wire logic [STAT_W-1:0] ev_in,
	input  wire logic              ev_clr,
	input  wire logic              en_wr,
	input  wire logic              en_clr,
	input  wire logic [STAT_W-1:0] en_data,
	output logic      [STAT_W-1:0] ev_q,
	output logic      [STAT_W-1:0] en_q,
	output logic                   summary
);

	typedef struct packed {
		logic [STAT_W-1:0] ev;
		logic [STAT_W-1:0] en;
	} sbs_set_s;

	sbs_set_s st_r;
	sbs_set_s st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Next state: events latch, clear yields to a new event
	always_comb
	begin
		st_nxt = st_r;
		if (ev_clr)
			st_nxt.ev = '0;
		st_nxt.ev = (st_nxt.ev | ev_in) & bit_mask;
		if (en_clr)
			st_nxt.en = '0;
		if (en_wr)
			st_nxt.en = en_data & bit_mask;
	end

	// State registers, all zero at power-on
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_r <= '{ev: STAT_RST, en: STAT_RST};
		else
			st_r <= st_nxt;
	end

	assign ev_q = st_r.ev;
	assign en_q = st_r.en;
	assign summary = |(st_r.ev & st_r.en);

endmodule // sbs_event_set

// file: sim/sbs_host_model.sv
`timescale 1ns/1ps
// Bus controller: serial polls the block whenever it asks for service
module sbs_host_model
	import sbs_pkg::*;
(
	input	wire logic		mclk,
	input	wire logic		service_request,
	input	wire logic		poll_valid,
	input	wire logic [BYTE_W-1:0]	poll_byte,
	output	logic			serial_poll,
	output	logic [BYTE_W-1:0]	last_byte,
	output	logic [7:0]		polls
);
	initial
	begin
		serial_poll = 1'b0;
		last_byte = 8'h00;
		polls = 8'h00;
	end

	// One poll per raised request, launched off the falling edge
	always @(negedge mclk)
		serial_poll <= service_request && !serial_poll;

	// Keep the byte returned by each poll
	always @(posedge mclk)
		if (poll_valid)
		begin
			last_byte <= poll_byte;
			polls <= polls + 8'h01;
		end
endmodule // sbs_host_model

// file: sim/sbs_status_core_sva.sv
`timescale 1ns/1ps
// Watches the status byte, poll and query ports
module sbs_chk
	import sbs_pkg::*;
(
	input	wire logic		mclk,
	input	wire logic		rst,
	input	wire logic [STAT_W-1:0]	std_event_in,
	input	wire logic		output_queue_nonempty,
	input	wire logic		error_queue_push,
	input	wire logic		error_queue_pop,
	input	wire logic		clear_status,
	input	wire logic		queue_clear,
	input	wire logic		system_clear,
	input	wire logic		rd_req,
	input	wire logic [3:0]	rd_sel,
	input	wire logic		serial_poll,
	input	wire logic [STAT_W-1:0]	rd_data,
	input	wire logic		rd_valid,
	input	wire logic [BYTE_W-1:0]	poll_byte,
	input	wire logic		poll_valid,
	input	wire logic [BYTE_W-1:0]	status_summary_byte,
	input	wire logic		service_request,
	input	wire logic		error_queue_nonempty_flag,
	input	wire logic		questionable_summary_flag,
	input	wire logic		operation_summary_flag
);
	wire [7:0] sb = status_summary_byte;

	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);

	// Fixed and following bits of the status byte
	unused_bit_a: assert property (!sb[1])
		else $error("status byte bit 1 set");
	summary_map_a: assert property (sb[4] == output_queue_nonempty
		&& sb[2] == error_queue_nonempty_flag
		&& sb[7] == operation_summary_flag
		&& sb[3] == questionable_summary_flag)
		else $error("status byte summary bits misplaced");
	push_errq_a: assert property (error_queue_push && !clear_status
		&& !error_queue_pop && !queue_clear && !system_clear
		|=> error_queue_nonempty_flag)
		else $error("error queue flag not set by push");

	// Request raising and poll handling
	rqs_rise_a: assert property ($rose(sb[6]) && !serial_poll
		|=> service_request) else $error("no request after summary");
	poll_clear_a: assert property (serial_poll && service_request
		|=> !service_request) else $error("poll left request set");
	poll_byte_a: assert property (serial_poll |=> poll_valid
		&& poll_byte == (($past(sb) & 8'hBF)
		| {1'b0, $past(service_request), 6'h00}))
		else $error("poll byte wrong");

	// Query answers and clear status
	stb_read_a: assert property (rd_req && rd_sel == SBS_RD_STB
		|=> rd_valid && rd_data == {8'h00, $past(sb)})
		else $error("status byte query wrong");
	top_bit_a: assert property (rd_req |=> rd_valid && !rd_data[15])
		else $error("query without answer or top bit set");
	std_read_a: assert property (rd_req && rd_sel == SBS_RD_STD_EV
		&& std_event_in == 16'h0000 |=> !sb[5])
		else $error("standard summary kept after read");
	cls_errq_a: assert property (clear_status && !error_queue_push
		|=> !error_queue_nonempty_flag) else $error("error queue kept");

	cover property (serial_poll && service_request);
	cover property ($rose(service_request));
	cover property (rd_valid && sb[5]);
endmodule // sbs_chk

bind sbs_status_core sbs_chk u_chk (.mclk(mclk), .rst(rst),
	.std_event_in(std_event_in), .clear_status(clear_status),
	.output_queue_nonempty(output_queue_nonempty), .rd_req(rd_req),
	.error_queue_push(error_queue_push), .rd_sel(rd_sel),
	.error_queue_pop(error_queue_pop), .queue_clear(queue_clear),
	.system_clear(system_clear),
	.questionable_summary_flag(questionable_summary_flag),
	.serial_poll(serial_poll), .rd_data(rd_data), .rd_valid(rd_valid),
	.poll_byte(poll_byte), .poll_valid(poll_valid),
	.status_summary_byte(status_summary_byte),
	.service_request(service_request),
	.error_queue_nonempty_flag(error_queue_nonempty_flag),
	.operation_summary_flag(operation_summary_flag));

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import sbs_pkg::*;
;
	logic		mclk = 0, rst = 1, oqn = 0, spoll, rd_valid, srq, eflag;
	logic		qflag;
	logic [15:0]	ev [4], cnd [3], keep [6], rd_data, wr_data = 0, v;
	logic [8:0]	cmd = 0;
	logic [2:0]	wr_sel = 0;
	logic		rd_req = 0, poll_valid;
	logic [3:0]	rd_sel = 0;
	logic [7:0]	sb, poll_byte, last_byte, polls;
	int		error_cnt = 0, checked = 0, seed = 60, i, n, p;

	always #12.5 mclk = ~mclk;

	sbs_status_core dut (.mclk(mclk), .rst(rst), .std_event_in(ev[0]),
		.oper_event_in(ev[1]), .meas_event_in(ev[2]), .ques_event_in(ev[3]),
		.oper_cond_in(cnd[0]), .meas_cond_in(cnd[1]), .ques_cond_in(cnd[2]),
		.output_queue_nonempty(oqn), .clear_status(cmd[0]),
		.status_preset(cmd[1]), .queue_clear(cmd[2]), .system_clear(cmd[3]),
		.system_preset(cmd[4]), .instrument_reset(cmd[5]),
		.error_queue_push(cmd[6]), .error_queue_pop(cmd[7]),
		.output_queue_clear(cmd[8]), .wr_sel(wr_sel), .wr_data(wr_data),
		.rd_req(rd_req), .rd_sel(rd_sel), .serial_poll(spoll),
		.rd_data(rd_data), .rd_valid(rd_valid), .poll_byte(poll_byte),
		.poll_valid(poll_valid), .status_summary_byte(sb),
		.service_request(srq), .error_queue_nonempty_flag(eflag),
		.questionable_summary_flag(qflag), .operation_summary_flag());

	sbs_host_model host (.mclk(mclk), .service_request(srq),
		.poll_valid(poll_valid), .poll_byte(poll_byte),
		.serial_poll(spoll), .last_byte(last_byte), .polls(polls));

	////////////////////////////////////////////////////////////////////////
	// Verdict, comparison and bus tasks
	task finish_test;
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task rchk(input logic [3:0] s, input logic [15:0] e);
		@(negedge mclk);
		rd_req = 1;
		rd_sel = s;
		@(negedge mclk);
		rd_req = 0;
		chk(16'(rd_valid), 16'h0001);
		chk(rd_data, e);
	endtask

	task wr(input int s, input logic [15:0] x);
		@(negedge mclk);
		wr_sel = 3'(s);
		wr_data = x;
		@(negedge mclk);
		wr_sel = 0;
	endtask

	task cp(input int k);
		@(negedge mclk);
		cmd[k] = 1;
		@(negedge mclk);
		cmd = 0;
	endtask

	task ep(input int k, input logic [15:0] x);
		@(negedge mclk);
		ev[k] = x;
		@(negedge mclk);
		ev[k] = 0;
	endtask

	// Query select and stored value of each enable register
	function automatic logic [3:0] en_rs(input int s);
		case (s)
			1: return 4'h3;
			5: return 4'h1;
			default: return 4'(3 * s - 1);
		endcase
	endfunction

	function automatic logic [15:0] en_exp(input int s, input logic [15:0] x);
		return (s == 1 || s == 5) ? (x & 16'h00FF) : (x & STAT_MASK);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		ev = '{4{16'h0000}};
		cnd = '{3{16'h0000}};
		repeat (2) @(negedge mclk);
		rst = 0;
		for (i = 0; i < 13; i++) rchk(4'(i), 16'h0000);
		for (i = 1; i < 6; i++)
		begin
			v = 16'($random(seed));
			keep[i] = en_exp(i, v);
			wr(i, v);
			rchk(en_rs(i), keep[i]);
		end
		for (i = 0; i < 6; i++)
		begin
			cp(6);
			cp(i);
			chk(16'(eflag), 16'(!(i == 0 || i == 2 || i == 3)));
		end
		for (i = 1; i < 6; i++)
			rchk(en_rs(i), (i == 1 || i == 5) ? keep[i] : 0);
		cp(0);
		for (i = 0; i < 4; i++)
		begin
			v = 16'($random(seed));
			ep(i, v);
			rchk(4'(i ? 3 * i + 1 : 2), v & (i ? STAT_MASK : STD_MASK));
		end
		cp(0);
		for (i = 1; i < 4; i++) rchk(4'(3 * i + 1), 16'h0000);
		wr(1, 16'h00FF);
		ep(0, 16'h0024);
		chk(16'(sb[5]), 16'h0001);
		rchk(4'h2, 16'h0024);
		chk(16'(sb[5]), 16'h0000);
		wr(4, 16'h0002);
		ep(3, 16'h0006);
		chk(16'(qflag), 16'h0001);
		cp(0);
		chk(16'(qflag), 16'h0000);
		for (i = 0; i < 3; i++)
		begin
			cnd[i] = 16'($random(seed));
			rchk(4'(3 * i + 6), cnd[i] & STAT_MASK);
		end
		wr(5, 16'd128);
		rchk(4'h1, 16'h0080);
		wr(2, 16'h0001);
		oqn = 1;
		p = polls;
		ep(1, 16'h8001);
		for (n = 0; n < 20 && polls == p; n++) @(negedge mclk);
		chk(16'(last_byte), 16'h00D0);
		if (polls == p)
		begin
			error_cnt++;
			finish_test;
		end
		chk(16'(srq), 16'h0000);
		chk(16'(sb), 16'h00D0);
		rchk(4'h0, 16'h00D0);
		wr(5, 16'h0084);
		p = polls;
		cp(6);
		for (n = 0; n < 20 && polls == p; n++) @(negedge mclk);
		chk(16'(last_byte), 16'h00D4);
		if (polls == p)
		begin
			error_cnt++;
			finish_test;
		end
		for (i = 1; i < 6; i++)
		begin
			wr(i, 16'h0000);
			rchk(en_rs(i), 16'h0000);
		end
		finish_test;
	end
endmodule // tb_top
